// ### rtl/siopt_pkg.sv
/*
  Shared constants, types and check-byte functions for the serial
  interface option block, its device end and its host end.
  Assumes both ends run on one clock and see the same link wires.
*/
package siopt_pkg;

  localparam int unsigned ADDR_W = 6;
  localparam int unsigned WORD_W = 24;
  localparam int unsigned RSP_W = 32;
  localparam int unsigned USER_NUM = 4;

  // register map
  localparam logic [5:0] STATUS_ADDR = 6'h00;
  localparam logic [5:0] OPTIONS_ADDR = 6'h02;
  localparam logic [5:0] CHECK_ADDR = 6'h03;
  localparam logic [5:0] RESULT_ADDR = 6'h04;
  localparam logic [5:0] USER_BASE = 6'h06;
  localparam logic [5:0] USER_LAST = 6'h09;

  // serial_interface_options fields
  localparam int unsigned OPT_CONTINUOUS_READOUT_ENABLE_BIT = 7;
  localparam int unsigned OPT_APPEND_BIT = 6;
  localparam int unsigned OPT_MONITOR_BIT = 5;
  localparam int unsigned OPT_CRC_LSB = 2;
  localparam int unsigned OPT_SHORT_BIT = 0;
  localparam logic [15:0] OPT_WMASK = 16'h00ed;
  localparam logic [15:0] OPT_RESET = 16'h0000;
  localparam logic [15:0] USER_RESET = 16'h0000;

  // status byte fields
  localparam int unsigned STAT_PEND_N_BIT = 7;
  localparam int unsigned STAT_CRCERR_BIT = 6;
  localparam int unsigned STAT_REGERR_BIT = 5;

  // response lengths in bytes
  localparam logic [2:0] LEN_SHORT = 3'h2;
  localparam logic [2:0] LEN_FULL = 3'h3;
  localparam logic [2:0] LEN_REG = 3'h3;

  // crc polynomial without the top term
  localparam logic [7:0] CRC_POLY = 8'h07;

  typedef enum logic [1:0] {
    CRC_NONE = 2'b00,
    CRC_XOR = 2'b01,
    CRC_FULL = 2'b10,
    CRC_RSVD = 2'b11
  } siopt_crc_e;

  function automatic logic [7:0] crc8(input logic [31:0] w);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 31; i >= 0; i--)
    begin
      c = (c[7] ^ w[i]) ? ({c[6:0], 1'b0} ^ CRC_POLY) : {c[6:0], 1'b0};
    end
    return c;
  endfunction

  function automatic logic [7:0] xor8(input logic [31:0] w);
    return w[31:24] ^ w[23:16] ^ w[15:8] ^ w[7:0];
  endfunction

  // writes use crc in both protected modes, reads xor or crc
  function automatic logic [7:0] check_byte(input siopt_crc_e m, input logic wr,
                                            input logic [31:0] w);
    logic [7:0] r;
    r = 8'h00;
    if (m == CRC_FULL || (m == CRC_XOR && wr))
    begin
      r = crc8(w);
    end
    else if (m == CRC_XOR)
    begin
      r = xor8(w);
    end
    return r;
  endfunction

  function automatic logic protected_mode(input siopt_crc_e m);
    return (m == CRC_XOR) || (m == CRC_FULL);
  endfunction

  // request frame that the check byte covers
  function automatic logic [31:0] req_frame(input logic wr, input logic [5:0] a,
                                            input logic [23:0] d);
    return {wr, 1'b0, a, d};
  endfunction

endpackage

// ### rtl/siopt_link_if.sv
/*
  Register-transfer link between the host end and the device end.
  Assumes one shared clock; a request is a one-cycle pulse and the
  device answers with a one-cycle pulse on the next edge.
*/
`timescale 1ns/1ns
interface siopt_link_if;
  logic req_valid;
  logic req_write;
  logic [5:0] req_addr;
  logic [23:0] req_wdata;
  logic [7:0] req_check;
  logic rsp_valid;
  logic rsp_stream;
  logic rsp_err;
  logic [31:0] rsp_data;
  logic [2:0] rsp_bytes;
  logic [7:0] rsp_check;

  modport dev (
    input req_valid,
    input req_write,
    input req_addr,
    input req_wdata,
    input req_check,
    output rsp_valid,
    output rsp_stream,
    output rsp_err,
    output rsp_data,
    output rsp_bytes,
    output rsp_check
  );

  modport host (
    output req_valid,
    output req_write,
    output req_addr,
    output req_wdata,
    output req_check,
    input rsp_valid,
    input rsp_stream,
    input rsp_err,
    input rsp_data,
    input rsp_bytes,
    input rsp_check
  );
endinterface

// ### rtl/siopt_device.sv
/*
  Device end: option register, result register with optional status
  append and short word, integrity monitor, check bytes, continuous
  readout. Assumes conversion results arrive as one-cycle pulses from
  the converter core and requests arrive one at a time on the link.
*/
`timescale 1ns/1ns
module siopt_device (
  input wire logic CLK,
  input wire logic RST,
  input wire logic CONV_VALID,
  input wire logic [23:0] CONV_DATA,
  input wire logic [3:0] CONV_CHAN,
  input wire logic CONT_CONV,
  output logic CONT_READ,
  output logic INTEG_FAULT,
  output logic SHORT_WORD,
  siopt_link_if.dev LNK
);

  logic [15:0] opt_q;
  logic [15:0] user_q [siopt_pkg::USER_NUM];
  logic [23:0] ref_q;
  logic fault_q;
  logic crcerr_q;
  logic [23:0] data_q;
  logic short_q;
  logic [3:0] chan_q;
  logic pend_q;
  logic push_q;
  logic rsp_valid_q;
  logic rsp_stream_q;
  logic rsp_err_q;
  logic [31:0] rsp_data_q;
  logic [2:0] rsp_bytes_q;
  logic [7:0] rsp_check_q;

  function automatic logic [23:0] user_sum(input logic [15:0] u [siopt_pkg::USER_NUM]);
    logic [23:0] s;
    s = 24'h000000;
    for (int i = 0; i < siopt_pkg::USER_NUM; i++)
    begin
      s = s ^ {8'h00, u[i]};
    end
    return s;
  endfunction

  wire siopt_pkg::siopt_crc_e crc_mode =
    siopt_pkg::siopt_crc_e'(opt_q[siopt_pkg::OPT_CRC_LSB +: 2]);
  wire continuous_readout_enable = opt_q[siopt_pkg::OPT_CONTINUOUS_READOUT_ENABLE_BIT];
  wire append = opt_q[siopt_pkg::OPT_APPEND_BIT];
  wire monitor = opt_q[siopt_pkg::OPT_MONITOR_BIT];
  wire short_sel = opt_q[siopt_pkg::OPT_SHORT_BIT];

  // request check byte; code 11 behaves as unprotected
  wire [31:0] frame = siopt_pkg::req_frame(LNK.req_write, LNK.req_addr, LNK.req_wdata);
  wire [7:0] want_check = siopt_pkg::check_byte(crc_mode, LNK.req_write, frame);
  wire chk_ok = !siopt_pkg::protected_mode(crc_mode) || (LNK.req_check == want_check);
  wire wr = LNK.req_valid && LNK.req_write && chk_ok;
  wire rd = LNK.req_valid && !LNK.req_write && chk_ok;
  wire bad = LNK.req_valid && !chk_ok;

  // monitored set is the user bank only
  wire user_hit = (LNK.req_addr >= siopt_pkg::USER_BASE)
                  && (LNK.req_addr <= siopt_pkg::USER_LAST);
  wire [5:0] user_off = LNK.req_addr - siopt_pkg::USER_BASE;
  wire [1:0] user_idx = user_off[1:0];
  wire opt_wr = wr && (LNK.req_addr == siopt_pkg::OPTIONS_ADDR);
  wire user_wr = wr && user_hit;
  wire mon_clr = opt_wr && !LNK.req_wdata[siopt_pkg::OPT_MONITOR_BIT];
  wire mon_arm = opt_wr && LNK.req_wdata[siopt_pkg::OPT_MONITOR_BIT] && !monitor;

  wire [23:0] live_sum = user_sum(user_q);
  // a standing mismatch yields to the clearing write
  wire fault_set = monitor && !mon_clr && (live_sum != ref_q);
  wire [23:0] check_reg = monitor ? live_sum : 24'h000000;

  wire [7:0] status = {~pend_q, crcerr_q, fault_q, 1'b0, chan_q};
  wire rd_status = rd && (LNK.req_addr == siopt_pkg::STATUS_ADDR);
  wire rd_result = rd && (LNK.req_addr == siopt_pkg::RESULT_ADDR);

  // result word, short length fixed when the result was taken, status append from the live option
  wire [31:0] res_word = !append ? {8'h00, data_q}
                       : short_q ? {8'h00, data_q[15:0], status}
                       : {data_q, status};
  wire [2:0] res_len = (short_q ? siopt_pkg::LEN_SHORT : siopt_pkg::LEN_FULL)
                       + {2'b00, append};

  wire [31:0] reg_word = (LNK.req_addr == siopt_pkg::STATUS_ADDR) ? {24'h000000, status}
                       : (LNK.req_addr == siopt_pkg::OPTIONS_ADDR) ? {16'h0000, opt_q}
                       : (LNK.req_addr == siopt_pkg::CHECK_ADDR) ? {8'h00, check_reg}
                       : user_hit ? {16'h0000, user_q[user_idx]}
                       : 32'h00000000;

  // stream a fresh result unless a request owns the answer slot
  wire conv_push = CONV_VALID && continuous_readout_enable && CONT_CONV;
  wire stream_go = push_q && !LNK.req_valid;
  wire push_d = conv_push || (push_q && LNK.req_valid);

  wire [31:0] ans_word = stream_go ? res_word
                       : (LNK.req_addr == siopt_pkg::RESULT_ADDR) ? res_word
                       : reg_word;
  wire [2:0] ans_len = (stream_go || (LNK.req_addr == siopt_pkg::RESULT_ADDR))
                       ? res_len : siopt_pkg::LEN_REG;
  wire rsp_d = LNK.req_valid || stream_go;
  wire [31:0] rsp_word = (LNK.req_write && !stream_go) ? 32'h00000000 : ans_word;
  wire [7:0] ans_check = siopt_pkg::check_byte(crc_mode, 1'b0, rsp_word);

  wire taken = rd_result || stream_go;
  wire pend_d = CONV_VALID || (pend_q && !taken);
  wire crcerr_d = bad || (crcerr_q && !rd_status);
  wire fault_d = fault_set || (fault_q && !mon_clr);

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      opt_q <= siopt_pkg::OPT_RESET;
      ref_q <= 24'h000000;
      fault_q <= 1'b0;
      crcerr_q <= 1'b0;
      pend_q <= 1'b0;
      push_q <= 1'b0;
    end
    else
    begin
      if (opt_wr)
      begin
        opt_q <= LNK.req_wdata[15:0] & siopt_pkg::OPT_WMASK;
      end
      if (mon_arm)
      begin
        ref_q <= live_sum;
      end
      fault_q <= fault_d;
      crcerr_q <= crcerr_d;
      pend_q <= pend_d;
      push_q <= push_d;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      for (int i = 0; i < siopt_pkg::USER_NUM; i++)
      begin
        user_q[i] <= siopt_pkg::USER_RESET;
      end
    end
    else if (user_wr)
    begin
      user_q[user_idx] <= LNK.req_wdata[15:0];
    end
  end

  // length follows the option at the moment a result completes
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      data_q <= 24'h000000;
      short_q <= 1'b0;
      chan_q <= 4'h0;
    end
    else if (CONV_VALID)
    begin
      data_q <= short_sel ? {8'h00, CONV_DATA[23:8]} : CONV_DATA;
      short_q <= short_sel;
      chan_q <= CONV_CHAN;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      rsp_valid_q <= 1'b0;
      rsp_stream_q <= 1'b0;
      rsp_err_q <= 1'b0;
      rsp_data_q <= 32'h00000000;
      rsp_bytes_q <= 3'h0;
      rsp_check_q <= 8'h00;
    end
    else
    begin
      rsp_valid_q <= rsp_d;
      rsp_stream_q <= stream_go;
      rsp_err_q <= bad;
      if (rsp_d)
      begin
        rsp_data_q <= rsp_word;
        rsp_bytes_q <= ans_len;
        rsp_check_q <= ans_check;
      end
    end
  end

  assign LNK.rsp_valid = rsp_valid_q;
  assign LNK.rsp_stream = rsp_stream_q;
  assign LNK.rsp_err = rsp_err_q;
  assign LNK.rsp_data = rsp_data_q;
  assign LNK.rsp_bytes = rsp_bytes_q;
  assign LNK.rsp_check = rsp_check_q;
  assign CONT_READ = continuous_readout_enable;
  assign INTEG_FAULT = fault_q;
  assign SHORT_WORD = short_sel;

endmodule

// ### rtl/siopt_host.sv
/*
  Host end: turns user commands into link requests, adds check bytes,
  cleans option writes and drops the monitor before user-bank writes.
  Assumes one command at a time and the device end on the same clock.
*/
`timescale 1ns/1ns
module siopt_host (
  input wire logic CLK,
  input wire logic RST,
  input wire logic CMD_VALID,
  output logic CMD_READY,
  input wire logic CMD_WRITE,
  input wire logic [5:0] CMD_ADDR,
  input wire logic [23:0] CMD_WDATA,
  input wire logic CONT_CONV_ON,
  output logic ANS_VALID,
  output logic [31:0] ANS_DATA,
  output logic ANS_ERR,
  output logic STREAM_VALID,
  output logic [31:0] STREAM_DATA,
  siopt_link_if.host LNK
);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PRE = 2'b01,
    ST_MAIN = 2'b10
  } siopt_hst_e;

  siopt_hst_e state_q;
  siopt_hst_e state_d;
  logic [15:0] shadow_q;
  logic cmd_write_q;
  logic [5:0] cmd_addr_q;
  logic [23:0] cmd_wdata_q;
  logic req_valid_q;
  logic req_write_q;
  logic [5:0] req_addr_q;
  logic [23:0] req_wdata_q;
  logic [7:0] req_check_q;
  logic ans_valid_q;
  logic ans_err_q;
  logic [31:0] ans_data_q;
  logic stream_valid_q;
  logic [31:0] stream_data_q;

  wire siopt_pkg::siopt_crc_e mode =
    siopt_pkg::siopt_crc_e'(shadow_q[siopt_pkg::OPT_CRC_LSB +: 2]);
  wire [15:0] mon_off = shadow_q & ~(16'h0001 << siopt_pkg::OPT_MONITOR_BIT);

  // option writes: reserved bits zero, readout only in continuous conversion,
  // code 11 turned into no protection
  wire [15:0] masked = CMD_WDATA[15:0] & siopt_pkg::OPT_WMASK;
  wire [15:0] no_cr = CONT_CONV_ON ? masked
                    : masked & ~(16'h0001 << siopt_pkg::OPT_CONTINUOUS_READOUT_ENABLE_BIT);
  wire [15:0] clean = (no_cr[siopt_pkg::OPT_CRC_LSB +: 2] == siopt_pkg::CRC_RSVD)
                    ? (no_cr & ~(16'h0003 << siopt_pkg::OPT_CRC_LSB)) : no_cr;
  wire is_opt = CMD_ADDR == siopt_pkg::OPTIONS_ADDR;
  wire [23:0] cmd_data = (CMD_WRITE && is_opt) ? {8'h00, clean} : CMD_WDATA;
  wire user_tgt = (CMD_ADDR >= siopt_pkg::USER_BASE) && (CMD_ADDR <= siopt_pkg::USER_LAST);
  wire need_pre = CMD_WRITE && user_tgt && shadow_q[siopt_pkg::OPT_MONITOR_BIT];

  wire accept = (state_q == ST_IDLE) && CMD_VALID;
  wire answer = LNK.rsp_valid && !LNK.rsp_stream;
  wire send_main = (accept && !need_pre) || ((state_q == ST_PRE) && answer);
  wire send_pre = accept && need_pre;

  wire nx_write = accept ? CMD_WRITE : cmd_write_q;
  wire [5:0] nx_addr = send_pre ? siopt_pkg::OPTIONS_ADDR : (accept ? CMD_ADDR : cmd_addr_q);
  wire [23:0] nx_data = send_pre ? {8'h00, mon_off} : (accept ? cmd_data : cmd_wdata_q);
  wire nx_wr = send_pre || nx_write;
  wire [7:0] nx_check = siopt_pkg::check_byte(mode, nx_wr,
                          siopt_pkg::req_frame(nx_wr, nx_addr, nx_data));
  wire nx_opt_wr = (send_pre || send_main) && nx_wr && (nx_addr == siopt_pkg::OPTIONS_ADDR);

  // reads checked against the mode in force
  wire [7:0] exp_check = siopt_pkg::check_byte(mode, 1'b0, LNK.rsp_data);
  wire chk_bad = siopt_pkg::protected_mode(mode) && !cmd_write_q
                 && (LNK.rsp_check != exp_check);
  wire stream_bad = siopt_pkg::protected_mode(mode) && (LNK.rsp_check != exp_check);

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:
      begin
        if (send_pre)
        begin
          state_d = ST_PRE;
        end
        else if (accept)
        begin
          state_d = ST_MAIN;
        end
      end
      ST_PRE:
      begin
        if (answer)
        begin
          state_d = ST_MAIN;
        end
      end
      ST_MAIN:
      begin
        if (answer)
        begin
          state_d = ST_IDLE;
        end
      end
      default:
      begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      state_q <= ST_IDLE;
      shadow_q <= siopt_pkg::OPT_RESET;
      cmd_write_q <= 1'b0;
      cmd_addr_q <= 6'h00;
      cmd_wdata_q <= 24'h000000;
    end
    else
    begin
      state_q <= state_d;
      if (nx_opt_wr)
      begin
        shadow_q <= nx_data[15:0];
      end
      if (accept)
      begin
        cmd_write_q <= CMD_WRITE;
        cmd_addr_q <= CMD_ADDR;
        cmd_wdata_q <= cmd_data;
      end
    end
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      req_valid_q <= 1'b0;
      req_write_q <= 1'b0;
      req_addr_q <= 6'h00;
      req_wdata_q <= 24'h000000;
      req_check_q <= 8'h00;
    end
    else
    begin
      req_valid_q <= send_pre || send_main;
      if (send_pre || send_main)
      begin
        req_write_q <= nx_wr;
        req_addr_q <= nx_addr;
        req_wdata_q <= nx_data;
        req_check_q <= nx_check;
      end
    end
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      ans_valid_q <= 1'b0;
      ans_err_q <= 1'b0;
      ans_data_q <= 32'h00000000;
      stream_valid_q <= 1'b0;
      stream_data_q <= 32'h00000000;
    end
    else
    begin
      ans_valid_q <= (state_q == ST_MAIN) && answer;
      stream_valid_q <= LNK.rsp_valid && LNK.rsp_stream;
      if ((state_q == ST_MAIN) && answer)
      begin
        ans_data_q <= LNK.rsp_data;
        ans_err_q <= LNK.rsp_err || chk_bad;
      end
      if (LNK.rsp_valid && LNK.rsp_stream)
      begin
        stream_data_q <= LNK.rsp_data;
        ans_err_q <= stream_bad;
      end
    end
  end

  assign CMD_READY = state_q == ST_IDLE;
  assign LNK.req_valid = req_valid_q;
  assign LNK.req_write = req_write_q;
  assign LNK.req_addr = req_addr_q;
  assign LNK.req_wdata = req_wdata_q;
  assign LNK.req_check = req_check_q;
  assign ANS_VALID = ans_valid_q;
  assign ANS_DATA = ans_data_q;
  assign ANS_ERR = ans_err_q;
  assign STREAM_VALID = stream_valid_q;
  assign STREAM_DATA = stream_data_q;

endmodule

// ### sim/siopt_link_props.sv
/*
  Concurrent checks on the link between the host end and the device end.
  Assumes it watches the shared link signals and the common clock and reset.
*/
`timescale 1ns/1ns
module siopt_link_props (
  input wire logic CLK,
  input wire logic RST,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [5:0] req_addr,
  input wire logic [23:0] req_wdata,
  input wire logic [7:0] req_check,
  input wire logic rsp_valid,
  input wire logic rsp_stream,
  input wire logic rsp_err,
  input wire logic [31:0] rsp_data,
  input wire logic [2:0] rsp_bytes,
  input wire logic [7:0] rsp_check
);
  logic lw_q;
  logic [5:0] la_q;
  logic [23:0] ld_q;
  logic [15:0] opt_q;
  wire logic ans = rsp_valid && !rsp_stream;
  wire logic rd_ans = ans && !lw_q && !rsp_err;
  wire logic opt_rd = rd_ans && la_q == siopt_pkg::OPTIONS_ADDR;
  wire logic opt_wr_ok = ans && lw_q && !rsp_err && la_q == siopt_pkg::OPTIONS_ADDR;
  wire logic [1:0] mode = opt_q[3:2];
  wire logic [7:0] rsp_xor = rsp_data[31:24] ^ rsp_data[23:16] ^ rsp_data[15:8] ^ rsp_data[7:0];

  // last request, the answer refers to it
  always_ff @(posedge CLK)
  begin
    if (req_valid)
    begin
      lw_q <= req_write;
      la_q <= req_addr;
      ld_q <= req_wdata;
    end
  end

  // option shadow from accepted writes
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      opt_q <= siopt_pkg::OPT_RESET;
    end
    else if (opt_wr_ok)
    begin
      opt_q <= ld_q[15:0] & siopt_pkg::OPT_WMASK;
    end
  end

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  answer_next_a: assert property (req_valid |=> rsp_valid && !rsp_stream)
    else $error("request not answered on the next cycle");
  plain_check_a: assert property (rsp_valid && !opt_wr_ok && mode[1] == mode[0]
    |-> rsp_check == 8'h00) else $error("check byte sent while unprotected");
  xor_read_a: assert property (rd_ans && mode == 2'b01 |-> rsp_check == rsp_xor)
    else $error("read check byte is not the xor sum");
  result_len_a: assert property (rd_ans && la_q == siopt_pkg::RESULT_ADDR
    |-> (rsp_bytes - {2'b00, opt_q[6]}) inside {3'h2, 3'h3}) else $error("bad result length");
  check_zero_a: assert property (rd_ans && la_q == siopt_pkg::CHECK_ADDR && !opt_q[5]
    |-> rsp_data == 32'h0) else $error("check register not zero while unmonitored");
  opt_reserved_a: assert property (opt_rd
    |-> (rsp_data & ~{16'h0, siopt_pkg::OPT_WMASK}) == 32'h0)
    else $error("reserved option bits read nonzero");
  opt_readback_a: assert property (opt_rd |-> rsp_data[15:0] == opt_q)
    else $error("option register does not read back");
  fault_clear_a: assert property (rd_ans && la_q == siopt_pkg::STATUS_ADDR && !opt_q[5]
    |-> !rsp_data[5]) else $error("fault flag set while monitor off");
endmodule

// ### sim/siopt_tb_top.sv
/*
  Bench for the option block: host end and device end joined by the link,
  random and corner options, result reads, integrity and streaming.
  Assumes the package, interface, both ends and the checker compile first.
*/
`timescale 1ns/1ns
module siopt_tb_top;
  logic clk, rst, cmd_valid, cmd_write, cont_conv_on, conv_valid, cont_conv;
  logic [5:0] cmd_addr;
  logic [23:0] cmd_wdata, conv_data, d;
  logic [3:0] conv_chan, ch;
  logic cmd_ready, ans_valid, ans_err, stream_valid, cont_read, integ_fault, short_word;
  logic [31:0] ans_data, stream_data, got;
  logic [15:0] v, x;
  logic [15:0] corner [5] = '{16'h0004, 16'h0008, 16'h000c, 16'hffff, 16'h0012};
  logic err;
  int failures, tests_run, lat, plain, n;

  siopt_link_if lnk ();
  siopt_device i_siopt_device (.CLK(clk), .RST(rst), .CONV_VALID(conv_valid),
    .CONV_DATA(conv_data), .CONV_CHAN(conv_chan), .CONT_CONV(cont_conv),
    .CONT_READ(cont_read), .INTEG_FAULT(integ_fault), .SHORT_WORD(short_word), .LNK(lnk));
  siopt_host i_siopt_host (.CLK(clk), .RST(rst), .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready),
    .CMD_WRITE(cmd_write), .CMD_ADDR(cmd_addr), .CMD_WDATA(cmd_wdata),
    .CONT_CONV_ON(cont_conv_on), .ANS_VALID(ans_valid), .ANS_DATA(ans_data), .ANS_ERR(ans_err),
    .STREAM_VALID(stream_valid), .STREAM_DATA(stream_data), .LNK(lnk));
  siopt_link_props i_siopt_link_props (.CLK(clk), .RST(rst), .req_valid(lnk.req_valid),
    .req_write(lnk.req_write), .req_addr(lnk.req_addr), .req_wdata(lnk.req_wdata),
    .req_check(lnk.req_check), .rsp_valid(lnk.rsp_valid), .rsp_stream(lnk.rsp_stream),
    .rsp_err(lnk.rsp_err), .rsp_data(lnk.rsp_data), .rsp_bytes(lnk.rsp_bytes),
    .rsp_check(lnk.rsp_check));

  function automatic logic [15:0] opt_clean(input logic [15:0] w, input logic cc);
    logic [15:0] r;
    r = w & 16'h00ed;
    r[7] = r[7] & cc;
    if (r[3:2] == 2'b11)
    begin
      r[3:2] = 2'b00;
    end
    return r;
  endfunction

  function automatic logic [31:0] exp_result(input logic [23:0] dv, input logic [3:0] c,
                                             input logic sh, input logic ap);
    return ap ? (sh ? {8'h00, dv[23:8], 4'h0, c} : {dv, 4'h0, c})
              : (sh ? {16'h0000, dv[23:8]} : {8'h00, dv});
  endfunction

  task automatic chk32(input string what, input logic [31:0] exp, input logic [31:0] seen);
    tests_run++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // called at a falling edge; returns answer and cycles from take to answer
  task automatic cmd(input logic wr, input logic [5:0] a, input logic [23:0] wd);
    cmd_valid = 1'b1;
    cmd_write = wr;
    cmd_addr = a;
    cmd_wdata = wd;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 50)
    begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    cmd_valid = 1'b0;
    chk32("ready while busy", 32'h0, {31'h0, cmd_ready});
    lat = 1;
    while (ans_valid !== 1'b1 && lat < 20)
    begin
      @(negedge clk);
      lat++;
    end
    chk32("answer pulse", 32'h1, {31'h0, ans_valid});
    chk32("answer error", 32'h0, {31'h0, ans_err});
    got = ans_data;
    @(negedge clk);
    chk32("answer drop", 32'h0, {31'h0, ans_valid});
  endtask

  task automatic conv(input logic [23:0] dv, input logic [3:0] c);
    conv_valid = 1'b1;
    conv_data = dv;
    conv_chan = c;
    @(negedge clk);
    conv_valid = 1'b0;
    @(negedge clk);
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
    begin
      $display("NO MISMATCHES");
    end
    else
    begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial
  begin
    #200000;
    failures++;
    give_verdict();
  end

  initial
  begin
    failures = 0;
    tests_run = 0;
    {rst, cmd_valid, cmd_write, cont_conv_on, conv_valid, cont_conv} = 6'b100000;
    {cmd_addr, cmd_wdata, conv_data, conv_chan} = '0;
    void'($urandom(32'hab9bab0c));
    repeat (4) @(negedge clk);
    rst = 1'b0;
    cmd(1'b0, siopt_pkg::OPTIONS_ADDR, 24'h0);
    chk32("options reset", 32'h0, got);
    cmd(1'b0, siopt_pkg::STATUS_ADDR, 24'h0);
    chk32("status reset", 32'h80, got);
    // corner codes first, then random options under random conversion state
    for (int i = 0; i < 14; i++)
    begin
      v = (i < 5) ? corner[i] : 16'($urandom);
      cont_conv_on = 1'($urandom);
      cont_conv = cont_conv_on;
      cmd(1'b1, siopt_pkg::OPTIONS_ADDR, {8'h00, v});
      cmd(1'b0, siopt_pkg::OPTIONS_ADDR, 24'h0);
      x = opt_clean(v, cont_conv_on);
      chk32("options readback", {16'h0, x}, got);
      chk32("short output", {31'h0, x[0]}, {31'h0, short_word});
      chk32("readout output", {31'h0, x[7]}, {31'h0, cont_read});
    end
    cont_conv_on = 1'b0;
    cont_conv = 1'b0;
    // every pairing of short word and status append
    for (int m = 0; m < 4; m++)
    begin
      cmd(1'b1, siopt_pkg::OPTIONS_ADDR, {17'h0, m[1], 5'h0, m[0]});
      d = 24'($urandom);
      ch = 4'($urandom);
      conv(d, ch);
      cmd(1'b0, siopt_pkg::RESULT_ADDR, 24'h0);
      chk32("result word", exp_result(d, ch, m[0], m[1]), got);
      chk32("result bytes", {29'h0, 3'(3 - m[0] + m[1])}, {29'h0, lnk.rsp_bytes});
    end
    cmd(1'b0, siopt_pkg::STATUS_ADDR, 24'h0);
    chk32("status after read", {24'h0, 4'h8, ch}, got);
    // length change lands only on the next result
    cmd(1'b1, siopt_pkg::OPTIONS_ADDR, 24'h0);
    d = 24'($urandom);
    conv(d, ch);
    cmd(1'b1, siopt_pkg::OPTIONS_ADDR, 24'h1);
    cmd(1'b0, siopt_pkg::RESULT_ADDR, 24'h0);
    chk32("held result", exp_result(d, ch, 1'b0, 1'b0), got);
    d = 24'($urandom);
    conv(d, ch);
    cmd(1'b0, siopt_pkg::RESULT_ADDR, 24'h0);
    chk32("new result", exp_result(d, ch, 1'b1, 1'b0), got);
    // integrity monitor over the user bank
    cmd(1'b1, siopt_pkg::OPTIONS_ADDR, 24'h0);
    x = 16'h0;
    for (int k = 0; k < 4; k++)
    begin
      v = 16'($urandom);
      x = x ^ v;
      cmd(1'b1, siopt_pkg::USER_BASE + 6'(k), {8'h00, v});
      plain = lat;
    end
    cmd(1'b1, siopt_pkg::OPTIONS_ADDR, 24'h20);
    cmd(1'b0, siopt_pkg::CHECK_ADDR, 24'h0);
    chk32("check sum", {16'h0, x}, got);
    conv(24'($urandom), ch);
    chk32("fault after result", 32'h0, {31'h0, integ_fault});
    v = 16'($urandom);
    cmd(1'b1, siopt_pkg::USER_BASE + 6'h2, {8'h00, v});
    chk32("prewrite cycles", 32'h2, 32'(lat - plain));
    chk32("fault after write", 32'h0, {31'h0, integ_fault});
    cmd(1'b0, siopt_pkg::OPTIONS_ADDR, 24'h0);
    chk32("monitor dropped", 32'h0, got);
    cmd(1'b0, siopt_pkg::CHECK_ADDR, 24'h0);
    chk32("check while off", 32'h0, got);
    cmd(1'b0, siopt_pkg::USER_BASE + 6'h2, 24'h0);
    chk32("user readback", {16'h0, v}, got);
    // continuous readout with status append
    cont_conv_on = 1'b1;
    cont_conv = 1'b1;
    cmd(1'b1, siopt_pkg::OPTIONS_ADDR, 24'hc0);
    chk32("readout on", 32'h1, {31'h0, cont_read});
    d = 24'($urandom);
    ch = 4'($urandom);
    conv_valid = 1'b1;
    conv_data = d;
    conv_chan = ch;
    @(negedge clk);
    conv_valid = 1'b0;
    n = 0;
    while (stream_valid !== 1'b1 && n < 10)
    begin
      @(negedge clk);
      n++;
    end
    chk32("stream pulse", 32'h1, {31'h0, stream_valid});
    chk32("stream word", exp_result(d, ch, 1'b0, 1'b1), stream_data);
    cont_conv_on = 1'b0;
    cmd(1'b1, siopt_pkg::OPTIONS_ADDR, 24'h80);
    chk32("readout refused", 32'h0, {31'h0, cont_read});
    give_verdict();
  end
endmodule
